/* hw/rie_top.sv */
// Purpose: resolver excitation, angle conversion and incremental A/B/Z generation
// Assumes: sine/cosine samples come from a converter clocked by SYS_CLK; switches are raw pins
// Notes:   one edge step per clock, far above any rated edge rate
`timescale 1ns/10ps
module rie_top (
	// clock and reset
	input  wire logic                          SYS_CLK,
	input  wire logic                          RST_N,
	// configuration switches, raw pins
	input  wire logic [2:0]                    CFG_SW,
	// returned windings, signed samples
	input  wire logic [rie_pkg::ADC_W-1:0]     SIN_SAMPLE,
	input  wire logic [rie_pkg::ADC_W-1:0]     COS_SAMPLE,
	// excitation output to the primary winding
	output logic      [rie_pkg::DAC_W-1:0]     EXC_DAC,
	// incremental outputs to the process_signal_port
	output rie_pkg::rie_quad_t                 QUAD_OUT,
	// avalon-mm slave
	input  wire logic [3:0]                    AVS_ADDRESS,
	input  wire logic                          AVS_READ,
	input  wire logic                          AVS_WRITE,
	input  wire logic [31:0]                   AVS_WRITEDATA,
	output logic      [31:0]                   AVS_READDATA,
	output logic                               AVS_WAITREQUEST
);

	// switch synchroniser
	logic [2:0]             sw_meta_q;
	logic [2:0]             sw_q;

	// excitation timing
	logic [5:0]             sub_q, sub_d;
	logic [5:0]             step_q, step_d;
	logic [rie_pkg::ROM_AW-1:0] rom_addr;
	logic [6:0]             rom_data;
	logic                   neg_half_q, neg_half_d;
	logic [7:0]             dac_q, dac_d;
	logic                   sample_now;

	// cordic
	typedef enum logic [0:0] {
		CS_IDLE = 1'b0,
		CS_RUN  = 1'b1
	} rie_cstate_t;
	rie_cstate_t            cst_q, cst_d;
	logic signed [rie_pkg::CW-1:0] cx_q, cx_d, cy_q, cy_d;
	logic [15:0]            cz_q, cz_d;
	logic [3:0]             it_q, it_d;
	logic [15:0]            angle_q, angle_d;
	logic                   angle_new_q, angle_new_d;

	// incremental tracker
	logic [15:0]            count_q, count_d;
	logic [1:0]             res_prev_q, res_prev_d;
	logic                   locked_q, locked_d;
	logic                   ovs_q, ovs_d;

	// registers and bus
	rie_pkg::rie_ctrl_t     ctrl_q, ctrl_d;
	logic                   ack_q, ack_d;
	logic [31:0]            rdata_q, rdata_d;

	// derived
	rie_pkg::rie_res_t      res;
	logic                   reset_mode;
	logic [3:0]             shift;
	logic [15:0]            mask;
	logic [15:0]            target;
	logic [15:0]            diff;
	logic [15:0]            dang;
	logic [15:0]            dabs;

	// two flip-flops on the switch pins
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sw_meta_q <= 3'h0;
			sw_q      <= 3'h0;
		end else begin
			sw_meta_q <= CFG_SW;
			sw_q      <= sw_meta_q;
		end
	end

	assign res        = rie_pkg::rie_res_t'({sw_q[0], sw_q[1]});
	assign reset_mode = sw_q[2] | ctrl_q.sw_reset;
	assign shift      = rie_pkg::res_shift(res);
	assign mask       = 16'hFFFF >> shift;
	assign target     = angle_q >> shift;

	// excitation step counters, 50 clocks per table step
	always_comb begin
		sub_d      = sub_q;
		step_d     = step_q;
		neg_half_d = neg_half_q;
		if (sub_q == 6'(rie_pkg::STEP_CYC - 1)) begin
			sub_d = 6'h00;
			if (step_q == 6'(rie_pkg::ROM_STEPS / 2 - 1)) begin
				step_d     = 6'h00;
				neg_half_d = ~neg_half_q;
			end else begin
				step_d = step_q + 6'h01;
			end
		end else begin
			sub_d = sub_q + 6'h01;
		end
	end

	// fold the half wave onto the quarter table
	assign rom_addr = (step_q <= 6'(rie_pkg::QUARTER_STEPS)) ? step_q[3:0]
		: 4'(6'(rie_pkg::ROM_STEPS / 2) - step_q);

	rie_sine_rom u_rom (
		.clk   (SYS_CLK),
		.rst_n (RST_N),
		.addr  (rom_addr),
		.data  (rom_data)
	);

	// offset-binary drive, parked at mid-scale when disabled
	always_comb begin
		if (!ctrl_q.exc_en) begin
			dac_d = rie_pkg::DAC_MID;
		end else if (neg_half_q) begin
			dac_d = rie_pkg::DAC_MID - {1'b0, rom_data};
		end else begin
			dac_d = rie_pkg::DAC_MID + {1'b0, rom_data};
		end
	end

	// positive crest: the demodulated amplitude carries the sign
	assign sample_now = !neg_half_q && step_q == 6'(rie_pkg::SAMPLE_STEP)
		&& sub_q == 6'(rie_pkg::SAMPLE_SUB);

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sub_q      <= 6'h00;
			step_q     <= 6'h00;
			neg_half_q <= 1'b0;
			dac_q      <= rie_pkg::DAC_MID;
		end else begin
			sub_q      <= sub_d;
			step_q     <= step_d;
			neg_half_q <= neg_half_d;
			dac_q      <= dac_d;
		end
	end

	// vectoring cordic turns sin/cos into an angle
	always_comb begin
		cst_d       = cst_q;
		cx_d        = cx_q;
		cy_d        = cy_q;
		cz_d        = cz_q;
		it_d        = it_q;
		angle_d     = angle_q;
		angle_new_d = 1'b0;
		case (cst_q)
			CS_IDLE: begin
				if (sample_now) begin
					cx_d = 16'(signed'(COS_SAMPLE));
					cy_d = 16'(signed'(SIN_SAMPLE));
					cz_d = 16'h0000;
					// left half plane: rotate by half a turn first
					if (COS_SAMPLE[rie_pkg::ADC_W-1]) begin
						cx_d = -16'(signed'(COS_SAMPLE));
						cy_d = -16'(signed'(SIN_SAMPLE));
						cz_d = 16'h8000;
					end
					it_d  = 4'h0;
					cst_d = CS_RUN;
				end
			end
			CS_RUN: begin
				if (cy_q >= 0) begin
					cx_d = cx_q + (cy_q >>> it_q);
					cy_d = cy_q - (cx_q >>> it_q);
					cz_d = cz_q + rie_pkg::atan_lut(it_q);
				end else begin
					cx_d = cx_q - (cy_q >>> it_q);
					cy_d = cy_q + (cx_q >>> it_q);
					cz_d = cz_q - rie_pkg::atan_lut(it_q);
				end
				it_d = it_q + 4'h1;
				if (it_q == 4'(rie_pkg::CORDIC_ITER - 1)) begin
					angle_d     = cz_d;
					angle_new_d = 1'b1;
					cst_d       = CS_IDLE;
				end
			end
			default: cst_d = CS_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cst_q       <= CS_IDLE;
			cx_q        <= 16'sh0000;
			cy_q        <= 16'sh0000;
			cz_q        <= 16'h0000;
			it_q        <= 4'h0;
			angle_q     <= 16'h0000;
			angle_new_q <= 1'b0;
		end else begin
			cst_q       <= cst_d;
			cx_q        <= cx_d;
			cy_q        <= cy_d;
			cz_q        <= cz_d;
			it_q        <= it_d;
			angle_q     <= angle_d;
			angle_new_q <= angle_new_d;
		end
	end

	// wrapped distance between target and emitted count
	assign diff = (target - count_q) & mask;
	// angle change over one excitation period
	assign dang = angle_d - angle_q;
	assign dabs = dang[15] ? 16'(-dang) : dang;

	// count walks one edge per clock toward the absolute angle
	always_comb begin
		count_d    = count_q;
		res_prev_d = res;
		locked_d   = (diff == 16'h0000);
		ovs_d      = ovs_q;
		if (reset_mode) begin
			// reset mode: counter held at zero
			count_d  = 16'h0000;
			locked_d = 1'b0;
		end else if (res != rie_pkg::rie_res_t'(res_prev_q)) begin
			// new scale: jump without emitting a burst
			count_d = target;
		end else if (diff != 16'h0000) begin
			// shortest way round sets the phase order for moves under a quarter turn
			if (diff[14 - shift] == 1'b0 || diff == (16'h0001 << (15 - shift))) begin
				count_d = (count_q + 16'h0001) & mask;
			end else begin
				count_d = (count_q - 16'h0001) & mask;
			end
		end
		// flag a move faster than the rated speed; set wins over clear
		if (angle_new_d && dabs > rie_pkg::max_step(res) && !reset_mode) begin
			ovs_d = 1'b1;
		end else if (AVS_WRITE && ack_q && AVS_ADDRESS == rie_pkg::REG_STATUS
			&& AVS_WRITEDATA[rie_pkg::ST_OVERSPEED]) begin
			ovs_d = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			count_q    <= 16'h0000;
			res_prev_q <= 2'h0;
			locked_q   <= 1'b0;
			ovs_q      <= 1'b0;
		end else begin
			count_q    <= count_d;
			res_prev_q <= res_prev_d;
			locked_q   <= locked_d;
			ovs_q      <= ovs_d;
		end
	end

	// gray-coded quadrature, index at count zero
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			QUAD_OUT <= '0;
		end else if (reset_mode) begin
			QUAD_OUT <= '0;
		end else begin
			QUAD_OUT.a <= count_d[1] ^ count_d[0];
			QUAD_OUT.b <= count_d[1];
			QUAD_OUT.z <= (count_d == 16'h0000);
		end
	end

	assign EXC_DAC = dac_q;

	// bus: one wait state, then the answer
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
	assign AVS_READDATA    = rdata_q;

	always_comb begin
		ack_d   = (AVS_READ | AVS_WRITE) & ~ack_q;
		ctrl_d  = ctrl_q;
		rdata_d = rdata_q;
		if (AVS_WRITE && ack_q && AVS_ADDRESS == rie_pkg::REG_CTRL) begin
			ctrl_d.exc_en   = AVS_WRITEDATA[rie_pkg::CTRL_EXC_EN];
			ctrl_d.sw_reset = AVS_WRITEDATA[rie_pkg::CTRL_SW_RESET];
		end
		// read data captured in the wait cycle, unmapped reads zero
		if (AVS_READ && !ack_q) begin
			case (AVS_ADDRESS)
				rie_pkg::REG_CTRL:   rdata_d = {30'h0000_0000, ctrl_q.sw_reset, ctrl_q.exc_en};
				rie_pkg::REG_STATUS: rdata_d = {26'h000_0000, ovs_q, locked_q, reset_mode, sw_q};
				rie_pkg::REG_ANGLE:  rdata_d = {16'h0000, angle_q};
				rie_pkg::REG_COUNT:  rdata_d = {16'h0000, count_q};
				default:             rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ack_q  <= 1'b0;
			ctrl_q <= '{sw_reset: rie_pkg::CTRL_SW_RESET_RST, exc_en: rie_pkg::CTRL_EXC_EN_RST};
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q   <= ack_d;
			ctrl_q  <= ctrl_d;
			rdata_q <= rdata_d;
		end
	end

endmodule : rie_top

/* hw/rie_pkg.sv */
// Purpose: shared constants, types and helpers for the resolver-to-incremental adapter
// Assumes: 20 MHz system clock, signed 12-bit sine/cosine samples from a converter on that clock
// Notes:   angles are 16-bit binary fractions of one turn (0x1_0000 would be a full turn)
package rie_pkg;

	// clock and excitation timing
	localparam int unsigned CLK_HZ         = 20_000_000;
	localparam int unsigned EXC_FREQ_KHZ   = 10;
	localparam int unsigned EXC_PERIOD_CYC = CLK_HZ / (EXC_FREQ_KHZ * 1000);
	localparam int unsigned ROM_STEPS      = 40;
	localparam int unsigned STEP_CYC       = EXC_PERIOD_CYC / ROM_STEPS;
	localparam int unsigned QUARTER_STEPS  = ROM_STEPS / 4;
	// excitation peak: sample the returned windings here
	localparam int unsigned SAMPLE_STEP    = QUARTER_STEPS;
	localparam int unsigned SAMPLE_SUB     = 0;
	localparam int unsigned CORDIC_ITER    = 14;

	// widths
	localparam int unsigned ADC_W   = 12;
	localparam int unsigned ANGLE_W = 16;
	localparam int unsigned DAC_W   = 8;
	localparam int unsigned ROM_AW  = 4;
	localparam int unsigned CW      = 16;

	// excitation dac mid-scale
	localparam logic [7:0] DAC_MID = 8'h80;

	// register byte offsets
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_ANGLE  = 4'h8;
	localparam logic [3:0] REG_COUNT  = 4'hC;

	// field positions
	localparam int unsigned CTRL_EXC_EN   = 0;
	localparam int unsigned CTRL_SW_RESET = 1;
	localparam int unsigned ST_SW_LSB     = 0;
	localparam int unsigned ST_RESET_MODE = 3;
	localparam int unsigned ST_LOCKED     = 4;
	localparam int unsigned ST_OVERSPEED  = 5;

	// reset values
	localparam logic        CTRL_EXC_EN_RST   = 1'b1;
	localparam logic        CTRL_SW_RESET_RST = 1'b0;

	// max speed per setting, revolutions per second
	localparam int unsigned MAX_RPS_16384 = 125;
	localparam int unsigned MAX_RPS_4096  = 500;
	localparam int unsigned MAX_RPS_1024  = 1000;
	localparam int unsigned MAX_RPS_256   = 2500;

	// resolution codes: switch1 is the high bit, switch2 the low bit
	typedef enum logic [1:0] {
		RES_16384 = 2'b00,
		RES_4096  = 2'b01,
		RES_1024  = 2'b10,
		RES_256   = 2'b11
	} rie_res_t;

	// incremental output carrier
	typedef struct packed {
		logic a;
		logic b;
		logic z;
	} rie_quad_t;

	// software control carrier
	typedef struct packed {
		logic sw_reset;
		logic exc_en;
	} rie_ctrl_t;

	// shift from 16-bit angle to edge count (4 edges per pulse)
	function automatic logic [3:0] res_shift(input rie_res_t r);
		case (r)
			RES_16384: res_shift = 4'h0;
			RES_4096:  res_shift = 4'h2;
			RES_1024:  res_shift = 4'h4;
			default:   res_shift = 4'h6;
		endcase
	endfunction : res_shift

	// largest angle change per excitation period at the rated speed
	function automatic logic [15:0] max_step(input rie_res_t r);
		int unsigned rps;
		case (r)
			RES_16384: rps = MAX_RPS_16384;
			RES_4096:  rps = MAX_RPS_4096;
			RES_1024:  rps = MAX_RPS_1024;
			default:   rps = MAX_RPS_256;
		endcase
		max_step = 16'((rps * 65536) / (EXC_FREQ_KHZ * 1000));
	endfunction : max_step

	// arctangent of 2^-i in angle units
	function automatic logic [15:0] atan_lut(input logic [3:0] i);
		case (i)
			4'h0:    atan_lut = 16'h2000;
			4'h1:    atan_lut = 16'h12E4;
			4'h2:    atan_lut = 16'h09FB;
			4'h3:    atan_lut = 16'h0511;
			4'h4:    atan_lut = 16'h028B;
			4'h5:    atan_lut = 16'h0146;
			4'h6:    atan_lut = 16'h00A3;
			4'h7:    atan_lut = 16'h0051;
			4'h8:    atan_lut = 16'h0029;
			4'h9:    atan_lut = 16'h0014;
			4'hA:    atan_lut = 16'h000A;
			4'hB:    atan_lut = 16'h0005;
			4'hC:    atan_lut = 16'h0003;
			default: atan_lut = 16'h0001;
		endcase
	endfunction : atan_lut

endpackage : rie_pkg

/* hw/rie_sine_rom.sv */
// Purpose: quarter-wave sine table for the excitation generator
// Assumes: index 0..10 covers 0..90 degrees in 9-degree steps
// Notes:   read data is registered, so it lags the address by one clock
`timescale 1ns/10ps
module rie_sine_rom (
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	// read port
	input  wire logic [rie_pkg::ROM_AW-1:0]   addr,
	output logic      [6:0]                   data
);

	logic [6:0] data_d;

	// amplitude 127 at the crest
	always_comb begin
		case (addr)
			4'h0:    data_d = 7'h00;
			4'h1:    data_d = 7'h14;
			4'h2:    data_d = 7'h27;
			4'h3:    data_d = 7'h3A;
			4'h4:    data_d = 7'h4B;
			4'h5:    data_d = 7'h5A;
			4'h6:    data_d = 7'h67;
			4'h7:    data_d = 7'h71;
			4'h8:    data_d = 7'h79;
			4'h9:    data_d = 7'h7D;
			default: data_d = 7'h7F;
		endcase
	end

	// registered read port
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data <= 7'h00;
		end else begin
			data <= data_d;
		end
	end

endmodule : rie_sine_rom

/* sim/rie_checker.sv */
// Purpose: port-level assertions for rie_top
// Assumes: one clock domain, reset active low
// Notes:   bound to every rie_top instance
`timescale 1ns/10ps
module rie_checker (
	// clock and reset
	input  wire logic                      SYS_CLK,
	input  wire logic                      RST_N,
	// pins
	input  wire logic [2:0]                CFG_SW,
	input  wire logic [rie_pkg::DAC_W-1:0] EXC_DAC,
	input  wire rie_pkg::rie_quad_t        QUAD_OUT,
	// bus
	input  wire logic [3:0]                AVS_ADDRESS,
	input  wire logic                      AVS_READ,
	input  wire logic                      AVS_WRITE,
	input  wire logic [31:0]               AVS_READDATA,
	input  wire logic                      AVS_WAITREQUEST
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);

	// a and b never move together, or the receiver loses count
	chk_gray_step: assert property (!($changed(QUAD_OUT.a) && $changed(QUAD_OUT.b)))
		else $error("a and b changed in one clock");
	chk_index_state: assert property (QUAD_OUT.z |-> !QUAD_OUT.a && !QUAD_OUT.b)
		else $error("index outside state zero");
	// six clocks covers the switch synchroniser and output register
	chk_reset_mode: assert property (CFG_SW[2] [*6] |-> QUAD_OUT == 3'b000)
		else $error("outputs active in reset mode");
	chk_exc_moves: assert property (1'b1 |-> ##[1:60] $changed(EXC_DAC))
		else $error("excitation stalled");
	chk_wait_once: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("more than one wait state");
	chk_wait_idle: assert property (!AVS_READ && !AVS_WRITE |-> !AVS_WAITREQUEST)
		else $error("wait with no request");
	chk_hole_zero: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[1:0] != 2'b00
		|-> AVS_READDATA == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_sw_status: assert property ($stable(CFG_SW) [*5] ##0 (AVS_READ && !AVS_WAITREQUEST
		&& AVS_ADDRESS == 4'h4) |-> AVS_READDATA[2:0] == CFG_SW)
		else $error("status switches wrong");

	// main scenarios
	cover_rst_mode: cover property (CFG_SW[2] ##1 !CFG_SW[2]);
	cover_up: cover property ($rose(QUAD_OUT.a) && !QUAD_OUT.b);
	cover_down: cover property ($rose(QUAD_OUT.a) && QUAD_OUT.b);
endmodule : rie_checker

bind rie_top rie_checker rie_checker_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CFG_SW(CFG_SW),
	.EXC_DAC(EXC_DAC), .QUAD_OUT(QUAD_OUT), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));

/* sim/rie_rx_model.sv */
// Purpose: receiving instrument's speed input, decoding A/B
// Assumes: pulses per turn set to match the switches
// Notes:   position is a signed edge count, never wrapped
`timescale 1ns/10ps
module rie_rx_model (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// incremental lines
	input  wire rie_pkg::rie_quad_t quad,
	// decoded state
	output int                      pos,
	output int                      bad
);
	logic [1:0] ph_q;
	logic [1:0] ph;

	// phase index: up count runs 0,1,2,3
	assign ph = {quad.b, quad.a ^ quad.b};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_q <= 2'b00;
			pos  <= 0;
			bad  <= 0;
		end else begin
			ph_q <= ph;
			case (2'(ph - ph_q))
				2'd1: pos <= pos + 1;
				2'd3: pos <= pos - 1;
				2'd2: bad <= bad + 1;
				default: ;
			endcase
		end
	end
endmodule : rie_rx_model

/* sim/rie_top_tb.sv */
// Purpose: self-checking bench for rie_top
// Assumes: resolver modelled here, receiver in rie_rx_model
// Notes:   one excitation period is 2000 clocks
`timescale 1ns/10ps
module rie_top_tb;
	logic               SYS_CLK = 1'b0;
	logic               RST_N = 1'b0;
	logic [2:0]         CFG_SW = 3'b011;
	logic [11:0]        SIN_SAMPLE;
	logic [11:0]        COS_SAMPLE;
	logic [7:0]         EXC_DAC;
	rie_pkg::rie_quad_t QUAD_OUT;
	logic [3:0]         AVS_ADDRESS = 4'h0;
	logic               AVS_READ = 1'b0;
	logic               AVS_WRITE = 1'b0;
	logic [31:0]        AVS_WRITEDATA = 32'h0000_0000;
	logic [31:0]        AVS_READDATA;
	logic               AVS_WAITREQUEST;
	logic [31:0]        ang = 32'h0000_0000;
	logic [31:0]        step = 32'h0000_0000;
	logic [31:0]        spin = 32'h0000_0000;
	logic [31:0]        shaft;
	logic [31:0]        rd;
	int                 error_cnt = 0;
	int                 n_compared = 0;
	int                 pos;
	int                 bad;
	real                ex;

	always #25 SYS_CLK = ~SYS_CLK;
	// spin turns by step each clock; tasks own ang, so no variable has two writers
	always @(posedge SYS_CLK) spin <= spin + step;
	// secondaries follow the excitation, so a dead exciter reads as zero
	always @* begin
		shaft = ang + spin;
		ex = 15.0 * ($signed({1'b0, EXC_DAC}) - 128);
		SIN_SAMPLE = 12'($rtoi(ex * $sin(6.283185307 * shaft / 4294967296.0)));
		COS_SAMPLE = 12'($rtoi(ex * $cos(6.283185307 * shaft / 4294967296.0)));
	end

	rie_top rie_top_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CFG_SW(CFG_SW), .SIN_SAMPLE(SIN_SAMPLE),
		.COS_SAMPLE(COS_SAMPLE), .EXC_DAC(EXC_DAC), .QUAD_OUT(QUAD_OUT), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
	rie_rx_model rie_rx_model_i (.clk(SYS_CLK), .rst_n(RST_N), .quad(QUAD_OUT), .pos(pos), .bad(bad));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one bus cycle, held until waitrequest is sampled low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge SYS_CLK);
		AVS_ADDRESS <= a;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		AVS_WRITEDATA <= d;
		do begin
			@(posedge SYS_CLK);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
		rd = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		chk(n < 50, 1'b1);
	endtask : bus

	// two excitation periods: sample, convert and count out
	task settle();
		repeat (4000) @(posedge SYS_CLK);
	endtask : settle

	task t_regs();
		bus(1'b0, 4'h0, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		bus(1'b0, 4'h4, 32'h0000_0000);
		chk(rd[3:0], 4'h3);
		bus(1'b0, 4'h2, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
	endtask : t_regs

	task t_exc();
		logic [7:0] hi;
		logic [7:0] lo;
		logic [7:0] v;
		hi = 8'h00;
		lo = 8'hFF;
		repeat (2000) begin
			@(posedge SYS_CLK);
			if (EXC_DAC > hi) hi = EXC_DAC;
			if (EXC_DAC < lo) lo = EXC_DAC;
		end
		chk(hi, 8'hFF);
		chk(lo, 8'h01);
		v = EXC_DAC;
		repeat (1000) @(posedge SYS_CLK);
		chk(v + EXC_DAC, 9'h100);
		repeat (1000) @(posedge SYS_CLK);
		chk(EXC_DAC, v);
	endtask : t_exc

	// quarter of the resolution per code step; tolerance covers converter error
	task t_res();
		int d;
		ang <= 32'h0400_0000;
		for (int c = 0; c < 4; c++) begin
			CFG_SW <= {1'b0, c[0], c[1]};
			settle();
			bus(1'b0, 4'hC, 32'h0000_0000);
			d = int'(rd) - (32'h400 >> (2 * c));
			chk(d <= (8 >> (2 * c)) + 1 && d >= -(8 >> (2 * c)) - 1, 1'b1);
		end
	endtask : t_res

	task t_dir();
		int p;
		CFG_SW <= 3'b011;
		ang <= 32'h0020_0000;
		settle();
		chk(QUAD_OUT, 3'b001);
		p = pos;
		ang <= 32'h0820_0000;
		settle();
		chk(pos - p, 32);
		ang <= 32'hF820_0000;
		settle();
		chk(pos - p, -32);
		chk(bad, 0);
		bus(1'b0, 4'hC, 32'h0000_0000);
		chk(rd, 32'd992);
	endtask : t_dir

	// just under and just over the 125 turns/s rating at 16384
	task t_speed();
		CFG_SW <= 3'b000;
		step <= 32'd26000;
		settle();
		bus(1'b1, 4'h4, 32'h0000_0020);
		settle();
		bus(1'b0, 4'h4, 32'h0000_0000);
		chk(rd[5], 1'b0);
		step <= 32'd30000;
		settle();
		bus(1'b0, 4'h4, 32'h0000_0000);
		chk(rd[5], 1'b1);
		step <= 32'd0;
		settle();
		bus(1'b1, 4'h4, 32'h0000_0020);
		bus(1'b0, 4'h4, 32'h0000_0000);
		chk(rd[5], 1'b0);
	endtask : t_speed

	task t_rmode();
		// park the shaft at angle zero so entering reset mode moves only the index line
		ang <= 32'h0000_0000 - spin;
		settle();
		CFG_SW <= 3'b100;
		repeat (10) @(posedge SYS_CLK);
		chk(QUAD_OUT, 3'b000);
		bus(1'b0, 4'h4, 32'h0000_0000);
		chk(rd[3], 1'b1);
		bus(1'b0, 4'hC, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		CFG_SW <= 3'b011;
		bus(1'b1, 4'h0, 32'h0000_0003);
		repeat (10) @(posedge SYS_CLK);
		chk(QUAD_OUT, 3'b000);
		bus(1'b1, 4'h0, 32'h0000_0001);
	endtask : t_rmode

	task summarize();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	// main sequence
	initial begin
		repeat (4) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		t_regs();
		t_exc();
		t_res();
		t_dir();
		t_speed();
		t_rmode();
		summarize();
	end

	// watchdog: tests need about 52000 clocks
	initial begin
		repeat (100000) @(posedge SYS_CLK);
		error_cnt++;
		summarize();
	end
endmodule : rie_top_tb
